// >>> logic/simd_dot_permute_pkg.sv
/*
  Shared constants and types of the packed-SIMD dot-product and
  permute unit. Assumes a 32-bit datapath in the host core.
*/
`default_nettype none
package simd_dot_permute_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned IMM_W  = 6;
  localparam int unsigned LANE_H = 2;
  localparam int unsigned LANE_B = 4;
  localparam int unsigned IDX_W  = 2;

  // Selector fields inside source 2
  localparam int unsigned HSEL_HI_BIT  = 16;
  localparam int unsigned HSEL_LO_BIT  = 0;
  localparam int unsigned HSRC_HI_BIT  = 17;
  localparam int unsigned HSRC_LO_BIT  = 1;
  localparam int unsigned BSRC_OFS_BIT = 2;

  localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;

  typedef enum logic [4:0] {
    unsigned_lane_product_sum,
    mixed_sign_lane_product_sum,
    signed_lane_product_sum,
    unsigned_lane_product_accumulate,
    mixed_sign_lane_product_accumulate,
    signed_lane_product_accumulate,
    halfword_lane_permute,
    halfword_lane_permute_immediate,
    byte_lane_permute,
    byte_permute_top_from_byte0,
    byte_permute_top_from_byte1,
    byte_permute_top_from_byte2,
    byte_permute_top_from_byte3,
    two_source_halfword_permute,
    two_source_byte_permute,
    low_halves_combine,
    high_halves_combine,
    upper_byte_pair_insert,
    lower_byte_pair_insert
  } op_e;

  typedef enum logic [1:0] {
    operand_vector,
    scalar_replicate_mode,
    operand_immediate
  } operand_mode_e;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] result;
  } state_s;

  localparam state_s STATE_RST = '{valid: 1'b0, result: RESULT_RST};

endpackage
`default_nettype wire

// >>> logic/simd_operand_if.sv
/*
  Operand bundle between the operand builder, the lane multiplier
  and the unit top. Assumes all three sit on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface simd_operand_if;
  import simd_dot_permute_pkg::*;

  logic [DATA_W-1:0] src1;
  logic [DATA_W-1:0] op2;
  logic [DATA_W-1:0] acc_base;
  logic [DATA_W-1:0] sum;
  logic              byte_lanes;
  logic              src1_signed;
  logic              op2_signed;

  modport source (
    output src1, op2, acc_base, byte_lanes, src1_signed, op2_signed
  );
  modport multiply (
    input  src1, op2, acc_base, byte_lanes, src1_signed, op2_signed,
    output sum
  );
endinterface
`default_nettype wire

// >>> logic/second_operand_builder.sv
/*
  Decodes signedness and builds the second operand of a dot product
  from source 2 or the six-bit immediate. Assumes combinational use.
*/
`timescale 1ns/1ps
`default_nettype none
module second_operand_builder (
  input  wire simd_dot_permute_pkg::op_e           op_in,
  input  wire simd_dot_permute_pkg::operand_mode_e mode_in,
  input  wire logic                                byte_lanes_in,
  input  wire logic [31:0]                         src1_in,
  input  wire logic [31:0]                         src2_in,
  input  wire logic [31:0]                         dest_old_in,
  input  wire logic [5:0]                          six_bit_immediate_in,
  simd_operand_if.source                           opnd
);
  import simd_dot_permute_pkg::*;

  logic [HALF_W-1:0] imm_h;
  logic [BYTE_W-1:0] imm_b;

  assign imm_h = {{(HALF_W-IMM_W){six_bit_immediate_in[IMM_W-1]}},
                  six_bit_immediate_in};
  assign imm_b = {{(BYTE_W-IMM_W){six_bit_immediate_in[IMM_W-1]}},
                  six_bit_immediate_in};

  always_comb
  begin
    opnd.op2 = src2_in;
    unique case (mode_in)
      operand_vector:
        opnd.op2 = src2_in;
      scalar_replicate_mode:
        opnd.op2 = byte_lanes_in ? {LANE_B{src2_in[BYTE_W-1:0]}}
                                 : {LANE_H{src2_in[HALF_W-1:0]}};
      operand_immediate:
        opnd.op2 = byte_lanes_in ? {LANE_B{imm_b}} : {LANE_H{imm_h}};
      default:
        opnd.op2 = src2_in;
    endcase
  end

  assign opnd.src1       = src1_in;
  assign opnd.byte_lanes = byte_lanes_in;
  assign opnd.src1_signed = (op_in == signed_lane_product_sum) ||
                            (op_in == signed_lane_product_accumulate);
  assign opnd.op2_signed = !((op_in == unsigned_lane_product_sum) ||
                           (op_in == unsigned_lane_product_accumulate));
  assign opnd.acc_base = ((op_in == unsigned_lane_product_accumulate) ||
                         (op_in == mixed_sign_lane_product_accumulate) ||
                         (op_in == signed_lane_product_accumulate))
                         ? dest_old_in : RESULT_RST;
endmodule
`default_nettype wire

// >>> logic/lane_product_summer.sv
/*
  Lane multipliers and adder tree for halfword and byte dot products.
  Assumes operands and signedness arrive on the operand bundle.
*/
`timescale 1ns/1ps
`default_nettype none
module lane_product_summer (
  simd_operand_if.multiply opnd
);
  import simd_dot_permute_pkg::*;

  logic [DATA_W-1:0] prod_b [LANE_B];
  logic [DATA_W-1:0] prod_h [LANE_H];

  genvar i;
  for (i = 0; i < LANE_B; i++)
  begin : g_byte
    logic signed [BYTE_W:0]     ea;
    logic signed [BYTE_W:0]     eb;
    logic signed [2*BYTE_W+1:0] p;
    assign ea = {opnd.src1_signed & opnd.src1[BYTE_W*i+BYTE_W-1],
                 opnd.src1[BYTE_W*i +: BYTE_W]};
    assign eb = {opnd.op2_signed & opnd.op2[BYTE_W*i+BYTE_W-1],
                 opnd.op2[BYTE_W*i +: BYTE_W]};
    assign p  = ea * eb;
    assign prod_b[i] = {{(DATA_W-2*BYTE_W-2){p[2*BYTE_W+1]}}, p};
  end

  for (i = 0; i < LANE_H; i++)
  begin : g_half
    logic signed [HALF_W:0]     ea;
    logic signed [HALF_W:0]     eb;
    logic signed [2*HALF_W+1:0] p;
    assign ea = {opnd.src1_signed & opnd.src1[HALF_W*i+HALF_W-1],
                 opnd.src1[HALF_W*i +: HALF_W]};
    assign eb = {opnd.op2_signed & opnd.op2[HALF_W*i+HALF_W-1],
                 opnd.op2[HALF_W*i +: HALF_W]};
    assign p  = ea * eb;
    assign prod_h[i] = p[DATA_W-1:0];
  end

  assign opnd.sum = opnd.acc_base + (opnd.byte_lanes
                    ? prod_b[0] + prod_b[1] + prod_b[2] + prod_b[3]
                    : prod_h[0] + prod_h[1]);
endmodule
`default_nettype wire

// >>> logic/simd_dot_product_permute_unit.sv
/*
  Packed-SIMD dot-product, permute and pack unit, one register stage.
  Assumes the pipeline presents all operands in the issue cycle.
*/
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////
module simd_dot_product_permute_unit (
  input  wire logic                                clk_sys_in,
  input  wire logic                                sys_rst_in,
  input  wire logic                                issue_valid_in,
  input  wire simd_dot_permute_pkg::op_e           op_in,
  input  wire simd_dot_permute_pkg::operand_mode_e operand_mode_in,
  input  wire logic                                byte_lanes_in,
  input  wire logic [31:0]                         src1_in,
  input  wire logic [31:0]                         src2_in,
  input  wire logic [31:0]                         dest_old_in,
  input  wire logic [5:0]                          six_bit_immediate_in,
  output logic                                     result_valid_out,
  output logic [31:0]                              result_out
);
  import simd_dot_permute_pkg::*;

  state_s                       state_reg;
  state_s                       state_next;
  logic [LANE_H-1:0][HALF_W-1:0] perm_h;
  logic [LANE_H-1:0][HALF_W-1:0] perm_imm_h;
  logic [LANE_H-1:0][HALF_W-1:0] perm2_h;
  logic [LANE_B-1:0][BYTE_W-1:0] perm_b;
  logic [LANE_B-1:0][BYTE_W-1:0] perm_imm_b;
  logic [LANE_B-1:0][BYTE_W-1:0] perm2_b;
  logic [IDX_W-1:0]             top_idx;

  ////////////////////////////////////////////////////////////////////
  // Dot-product datapath

  simd_operand_if opnd_if ();

  second_operand_builder u_builder (
    .op_in                (op_in),
    .mode_in              (operand_mode_in),
    .byte_lanes_in        (byte_lanes_in),
    .src1_in              (src1_in),
    .src2_in              (src2_in),
    .dest_old_in          (dest_old_in),
    .six_bit_immediate_in (six_bit_immediate_in),
    .opnd                 (opnd_if.source)
  );

  lane_product_summer u_summer (
    .opnd (opnd_if.multiply)
  );

  ////////////////////////////////////////////////////////////////////
  // Permute datapath

  function automatic logic [BYTE_W-1:0] pick_byte(
    input logic [DATA_W-1:0] w,
    input logic [IDX_W-1:0]  idx
  );
    pick_byte = w[{idx, 3'h0} +: BYTE_W];
  endfunction

  function automatic logic [HALF_W-1:0] pick_half(
    input logic [DATA_W-1:0] w,
    input logic              sel
  );
    pick_half = sel ? w[DATA_W-1:HALF_W] : w[HALF_W-1:0];
  endfunction

  assign perm_h[1] = pick_half(src1_in, src2_in[HSEL_HI_BIT]);
  assign perm_h[0] = pick_half(src1_in, src2_in[HSEL_LO_BIT]);

  assign perm_imm_h[1] = pick_half(src1_in, six_bit_immediate_in[1]);
  assign perm_imm_h[0] = pick_half(src1_in, six_bit_immediate_in[0]);

  assign perm2_h[1] = pick_half(src2_in[HSRC_HI_BIT] ? src1_in
                                : dest_old_in, src2_in[HSEL_HI_BIT]);
  assign perm2_h[0] = pick_half(src2_in[HSRC_LO_BIT] ? src1_in
                                : dest_old_in, src2_in[HSEL_LO_BIT]);

  always_comb
  begin
    top_idx = 2'h0;
    case (op_in)
      byte_permute_top_from_byte1: top_idx = 2'h1;
      byte_permute_top_from_byte2: top_idx = 2'h2;
      byte_permute_top_from_byte3: top_idx = 2'h3;
      default:                     top_idx = 2'h0;
    endcase
  end

  genvar i;
  // byte lane i at bits 8i
  for (i = 0; i < LANE_B; i++)
  begin : g_lane
    assign perm_b[i] = pick_byte(src1_in, src2_in[BYTE_W*i +: IDX_W]);
    assign perm2_b[i] = pick_byte(
      src2_in[BYTE_W*i+BSRC_OFS_BIT] ? src1_in : dest_old_in,
      src2_in[BYTE_W*i +: IDX_W]);
    if (i == LANE_B - 1)
    begin : g_top
      assign perm_imm_b[i] = pick_byte(src1_in, top_idx);
    end
    else
    begin : g_low
      assign perm_imm_b[i] =
        pick_byte(src1_in, six_bit_immediate_in[IDX_W*i +: IDX_W]);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Result select and register

  always_comb
  begin
    state_next       = state_reg;
    state_next.valid = issue_valid_in;
    if (issue_valid_in)
    begin
      unique case (op_in)
        unsigned_lane_product_sum,
        mixed_sign_lane_product_sum,
        signed_lane_product_sum,
        unsigned_lane_product_accumulate,
        mixed_sign_lane_product_accumulate,
        signed_lane_product_accumulate:
          state_next.result = opnd_if.sum;
        halfword_lane_permute:
          state_next.result = perm_h;
        halfword_lane_permute_immediate:
          state_next.result = perm_imm_h;
        byte_lane_permute:
          state_next.result = perm_b;
        byte_permute_top_from_byte0,
        byte_permute_top_from_byte1,
        byte_permute_top_from_byte2,
        byte_permute_top_from_byte3:
          state_next.result = perm_imm_b;
        two_source_halfword_permute:
          state_next.result = perm2_h;
        two_source_byte_permute:
          state_next.result = perm2_b;
        low_halves_combine:
          state_next.result = {src1_in[HALF_W-1:0], src2_in[HALF_W-1:0]};
        high_halves_combine:
          state_next.result = {src1_in[DATA_W-1:HALF_W],
                               src2_in[DATA_W-1:HALF_W]};
        upper_byte_pair_insert:
          state_next.result = {src1_in[BYTE_W-1:0], src2_in[BYTE_W-1:0],
                               dest_old_in[HALF_W-1:0]};
        lower_byte_pair_insert:
          state_next.result = {dest_old_in[DATA_W-1:HALF_W],
                               src1_in[BYTE_W-1:0], src2_in[BYTE_W-1:0]};
        // Undefined codes give zero, never stale data
        default:
          state_next.result = RESULT_RST;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      state_reg <= STATE_RST;
    else
      state_reg <= state_next;
  end

  assign result_valid_out = state_reg.valid;
  assign result_out       = state_reg.result;

  ////////////////////////////////////////////////////////////////////
  // Checks

  // Written loop-wise, unlike the multiplier, to catch slips there
  function automatic logic [DATA_W-1:0] ref_dot(
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b,
    input logic              bl,
    input logic              sa,
    input logic              sb
  );
    logic [DATA_W-1:0] acc;
    logic signed [HALF_W:0] ea;
    logic signed [HALF_W:0] eb;
    logic signed [2*HALF_W+1:0] pr;
    acc = '0;
    for (int k = 0; k < LANE_B; k++)
    begin
      ea = '0;
      eb = '0;
      if (bl)
      begin
        ea = {{(HALF_W-BYTE_W+1){sa & a[8*k+7]}}, a[8*k +: 8]};
        eb = {{(HALF_W-BYTE_W+1){sb & b[8*k+7]}}, b[8*k +: 8]};
      end
      else if (k < LANE_H)
      begin
        ea = {sa & a[16*k+15], a[16*k +: 16]};
        eb = {sb & b[16*k+15], b[16*k +: 16]};
      end
      pr = ea * eb;
      acc = acc + pr[DATA_W-1:0];
    end
    ref_dot = acc;
  endfunction

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence vec_issue(op_e op, logic bl);
    issue_valid_in && op_in == op && byte_lanes_in == bl &&
    operand_mode_in == operand_vector;
  endsequence

  latency_one_a : assert property (
    result_valid_out == $past(issue_valid_in))
    else $error("result valid not one cycle after issue");

  hdot_unsigned_a : assert property (
    vec_issue(unsigned_lane_product_sum, 1'b0) |=>
    result_out == 32'($past(src1_in[15:0]) * $past(src2_in[15:0]) +
                      $past(src1_in[31:16]) *
                      $past(src2_in[31:16])))
    else $error("unsigned halfword dot wrong");

  bdot_signed_a : assert property (
    vec_issue(signed_lane_product_sum, 1'b1) |=>
    result_out == ref_dot($past(src1_in), $past(src2_in), 1, 1, 1))
    else $error("signed byte dot wrong");

  mixed_sign_a : assert property (
    vec_issue(mixed_sign_lane_product_sum, 1'b1) |=>
    result_out == ref_dot($past(src1_in), $past(src2_in), 1, 0, 1))
    else $error("mixed byte dot wrong");

  mixed_acc_a : assert property (
    vec_issue(mixed_sign_lane_product_accumulate, 1'b0) |=>
    result_out == 32'($past(dest_old_in) +
      ref_dot($past(src1_in), $past(src2_in), 0, 0, 1)))
    else $error("mixed accumulate wrong");

  scalar_rep_a : assert property (
    issue_valid_in && op_in == unsigned_lane_product_sum &&
    operand_mode_in == scalar_replicate_mode && !byte_lanes_in |=>
    result_out == ref_dot($past(src1_in),
      {2{$past(src2_in[15:0])}}, 0, 0, 0))
    else $error("scalar replicate wrong");

  imm_sext_a : assert property (
    issue_valid_in && op_in == signed_lane_product_sum &&
    operand_mode_in == operand_immediate && byte_lanes_in |=>
    result_out == ref_dot($past(src1_in),
      {4{{{2{$past(six_bit_immediate_in[5])}},
      $past(six_bit_immediate_in)}}}, 1, 1, 1))
    else $error("immediate not sign extended");

  hperm_two_a : assert property (
    issue_valid_in && op_in == two_source_halfword_permute &&
    src2_in[17] && !src2_in[1] && src2_in[16] && !src2_in[0] |=>
    result_out == {$past(src1_in[31:16]), $past(dest_old_in[15:0])})
    else $error("two-source halfword permute wrong");

  bperm_reg_a : assert property (
    issue_valid_in && op_in == byte_lane_permute |=>
    result_out[31:24] ==
      8'($past(src1_in) >> {$past(src2_in[25:24]), 3'h0}))
    else $error("byte permute top byte wrong");

  bperm_imm_a : assert property (
    issue_valid_in && op_in == byte_permute_top_from_byte2 |=>
    result_out[31:24] == $past(src1_in[23:16]) &&
    result_out[7:0] == 8'($past(src1_in) >>
                          {$past(six_bit_immediate_in[1:0]), 3'h0}))
    else $error("immediate byte permute wrong");

  pack_halves_a : assert property (
    issue_valid_in && op_in == low_halves_combine |=>
    result_out == {$past(src1_in[15:0]), $past(src2_in[15:0])})
    else $error("low halves combine wrong");

  pair_keep_a : assert property (
    issue_valid_in && op_in == lower_byte_pair_insert |=>
    result_out[31:16] == $past(dest_old_in[31:16]) &&
    result_out[15:0] == {$past(src1_in[7:0]), $past(src2_in[7:0])})
    else $error("lower pair insert wrong");

  pack_high_a : assert property (
    issue_valid_in && op_in == high_halves_combine |=>
    result_out == {$past(src1_in[31:16]), $past(src2_in[31:16])})
    else $error("high halves combine wrong");

  pair_upper_a : assert property (
    issue_valid_in && op_in == upper_byte_pair_insert |=>
    result_out[15:0] == $past(dest_old_in[15:0]) &&
    result_out[31:16] == {$past(src1_in[7:0]), $past(src2_in[7:0])})
    else $error("upper pair insert wrong");

  hold_idle_a : assert property (
    !issue_valid_in |=> $stable(result_out))
    else $error("result moved without issue");

  acc_signed_c : cover property (
    issue_valid_in && op_in == signed_lane_product_accumulate);
  imm_bperm_c : cover property (
    issue_valid_in && op_in == byte_permute_top_from_byte3);
  two_src_c : cover property (
    issue_valid_in && op_in == two_source_byte_permute);
  back_to_back_c : cover property (
    issue_valid_in ##1 issue_valid_in);
  undef_code_c : cover property (
    issue_valid_in && op_in > lower_byte_pair_insert);

endmodule
`default_nettype wire

// >>> testbench/pipeline_issue_model.sv
/*
  Pipeline side of the dot-product and permute unit: issues one
  operation per call and collects the registered answer.
  Assumes the caller enters each call just after a falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pipeline_issue_model (
  input  wire logic                               clk_in,
  input  wire logic                               result_valid_in,
  input  wire logic [31:0]                        result_in,
  output var  logic                               issue_valid_out,
  output var  simd_dot_permute_pkg::op_e           op_out,
  output var  simd_dot_permute_pkg::operand_mode_e mode_out,
  output var  logic                               byte_lanes_out,
  output var  logic [31:0]                        src1_out,
  output var  logic [31:0]                        src2_out,
  output var  logic [31:0]                        dest_old_out,
  output var  logic [5:0]                         imm_out
);
  import simd_dot_permute_pkg::*;

  initial
  begin
    issue_valid_out = 1'b0;
    op_out = unsigned_lane_product_sum;
    mode_out = operand_vector;
    byte_lanes_out = 1'b0;
    src1_out = 32'h0;
    src2_out = 32'h0;
    dest_old_out = 32'h0;
    imm_out = 6'h0;
  end

  ////////////////////////////////////////////////////////////////////
  // Released operands show the inverse, never the stale value
  task automatic issue(input op_e o, operand_mode_e md, logic bl,
                       logic [31:0] s1, s2, d, logic [5:0] imm,
                       logic last, output logic v, output logic [31:0] r);
    issue_valid_out = 1'b1;
    op_out = o;
    mode_out = md;
    byte_lanes_out = bl;
    src1_out = s1;
    src2_out = s2;
    dest_old_out = d;
    imm_out = imm;
    @(negedge clk_in);
    v = result_valid_in;
    r = result_in;
    if (last)
    begin
      issue_valid_out = 1'b0;
      src1_out = ~s1;
      src2_out = ~s2;
      dest_old_out = ~d;
      imm_out = ~imm;
      // Idle cycle, so valid never rises again in the same step
      @(negedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/simd_dot_product_permute_unit_tb.sv
/*
  Self-checking bench of the dot-product and permute unit.
  Assumes the unit answers one cycle after each issue.
*/
`timescale 1ns/1ps
`default_nettype none
module simd_dot_product_permute_unit_tb;
  import simd_dot_permute_pkg::*;
  logic          clk_sys_in;
  logic          sys_rst_in;
  logic          iv;
  op_e           op;
  operand_mode_e md;
  logic          bl;
  logic [31:0]   s1;
  logic [31:0]   s2;
  logic [31:0]   d;
  logic [5:0]    imm;
  logic          rv;
  logic [31:0]   res;
  int            errors;
  int            tests_run;
  logic [31:0]   s1_t [3] = '{32'h80ff_7f01, 32'hffff_ffff, 32'h1234_8765};
  logic [31:0]   s2_t [3] = '{32'h0507_0304, 32'hffff_ffff, 32'h07fb_04fa};
  logic [31:0]   d_t  [3] = '{32'hffff_fff0, 32'h0, 32'h8000_0000};
  logic [5:0]    i_t  [3] = '{6'h25, 6'h1f, 6'h1a};

  pipeline_issue_model pipeline_issue_model_i (
    .clk_in(clk_sys_in), .result_valid_in(rv), .result_in(res),
    .issue_valid_out(iv), .op_out(op), .mode_out(md),
    .byte_lanes_out(bl), .src1_out(s1), .src2_out(s2),
    .dest_old_out(d), .imm_out(imm));

  simd_dot_product_permute_unit simd_dot_product_permute_unit_i (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .issue_valid_in(iv), .op_in(op), .operand_mode_in(md),
    .byte_lanes_in(bl), .src1_in(s1), .src2_in(s2), .dest_old_in(d),
    .six_bit_immediate_in(imm), .result_valid_out(rv),
    .result_out(res));

  always #20 clk_sys_in = ~clk_sys_in;

  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ext(logic [31:0] x, logic b, logic s);
    ext = b ? {{24{s & x[7]}}, x[7:0]} : {{16{s & x[15]}}, x[15:0]};
  endfunction

  function automatic logic [15:0] hw(logic [31:0] x, logic s);
    hw = s ? x[31:16] : x[15:0];
  endfunction

  function automatic logic [7:0] by(logic [31:0] x, logic [1:0] i);
    by = x[8*i +: 8];
  endfunction

  // Independent model; products and sums wrap at 32 bits
  function automatic logic [31:0] expect_res(op_e o, operand_mode_e m,
      logic b, logic [31:0] a1, a2, dd, logic [5:0] im);
    logic [31:0] o2;
    logic [31:0] acc;
    logic        sa;
    logic        sb;
    int          w;
    w = b ? 8 : 16;
    sa = o inside {signed_lane_product_sum, signed_lane_product_accumulate};
    sb = sa || o inside {mixed_sign_lane_product_sum,
                         mixed_sign_lane_product_accumulate};
    o2 = (m == operand_immediate) ? {{26{im[5]}}, im} : a2;
    case (o)
      halfword_lane_permute: return {hw(a1, a2[16]), hw(a1, a2[0])};
      halfword_lane_permute_immediate:
        return {hw(a1, im[1]), hw(a1, im[0])};
      byte_lane_permute: return {by(a1, a2[25:24]), by(a1, a2[17:16]),
                                 by(a1, a2[9:8]), by(a1, a2[1:0])};
      byte_permute_top_from_byte0, byte_permute_top_from_byte1,
      byte_permute_top_from_byte2, byte_permute_top_from_byte3:
        return {by(a1, 2'(o - byte_permute_top_from_byte0)),
                by(a1, im[5:4]), by(a1, im[3:2]), by(a1, im[1:0])};
      two_source_halfword_permute:
        return {hw(a2[17] ? a1 : dd, a2[16]), hw(a2[1] ? a1 : dd, a2[0])};
      two_source_byte_permute:
        return {by(a2[26] ? a1 : dd, a2[25:24]),
                by(a2[18] ? a1 : dd, a2[17:16]),
                by(a2[10] ? a1 : dd, a2[9:8]), by(a2[2] ? a1 : dd, a2[1:0])};
      low_halves_combine: return {a1[15:0], a2[15:0]};
      high_halves_combine: return {a1[31:16], a2[31:16]};
      upper_byte_pair_insert: return {a1[7:0], a2[7:0], dd[15:0]};
      lower_byte_pair_insert: return {dd[31:16], a1[7:0], a2[7:0]};
      default: ;
    endcase
    if (o > signed_lane_product_accumulate)
      return 32'h0;
    acc = (o >= unsigned_lane_product_accumulate) ? dd : 32'h0;
    for (int i = 0; i < (b ? 4 : 2); i++)
      acc = acc + ext(a1 >> (w * i), b, sa)
            * ext(o2 >> ((m == operand_vector) ? w * i : 0), b, sb);
    return acc;
  endfunction

  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run_one(input op_e o, operand_mode_e m, logic b, int n,
                         logic last);
    logic        v;
    logic [31:0] r;
    pipeline_issue_model_i.issue(o, m, b, s1_t[n], s2_t[n], d_t[n],
                                 i_t[n], last, v, r);
    check({31'h0, v}, 32'h1);
    check(r, expect_res(o, m, b, s1_t[n], s2_t[n], d_t[n], i_t[n]));
  endtask

  task automatic results();
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check({31'h0, rv}, 32'h0);
    check(res, 32'h0);
    sys_rst_in = 1'b0;
    @(negedge clk_sys_in);
    check({31'h0, rv}, 32'h0);
    check(res, 32'h0);
  endtask

  // Every flavour, lane width and operand mode, signed corners
  task automatic test_dot();
    for (int k = 0; k < 6; k++)
      for (int m = 0; m < 6; m++)
        for (int n = 0; n < 3; n++)
          run_one(op_e'(k), operand_mode_e'(m % 3), m >= 3, n, 1'b1); // dot products
  endtask

  // Mode and lane width set oddly: permutes must ignore them
  task automatic test_permute();
    for (int k = 6; k < 19; k++)
      for (int n = 0; n < 3; n++)
        run_one(op_e'(k), operand_immediate, 1'b1, n, 1'b1); // permutes
  endtask

  // Back to back issues, an unknown code, then an idle hold
  task automatic test_back_to_back();
    run_one(signed_lane_product_accumulate, scalar_replicate_mode, 1'b1,
            0, 1'b0); // accumulate back to back
    run_one(op_e'(5'd19), operand_vector, 1'b0, 1, 1'b0);
    run_one(two_source_byte_permute, operand_vector, 1'b0, 2, 1'b1); // two-source
    @(negedge clk_sys_in);
    check({31'h0, rv}, 32'h0);
    check(res, expect_res(two_source_byte_permute, operand_vector, 1'b0,
                          s1_t[2], s2_t[2], d_t[2], i_t[2])); // hold
  endtask

  initial
  begin
    clk_sys_in = 1'b0;
    sys_rst_in = 1'b1;
    errors = 0;
    tests_run = 0;
    repeat (20) @(negedge clk_sys_in);
    test_reset();
    test_dot();
    test_permute();
    test_back_to_back();
    results();
  end

  // Run needs about 320 cycles; allow over twelve times that
  initial
  begin
    repeat (4000) @(posedge clk_sys_in);
    errors++;
    results();
  end
endmodule
`default_nettype wire
